//--- src/gpio_pkg.sv
// Purpose: Shared constants and types for the dual GPIO port block
// Assumes: 32-bit Avalon-MM slave, one register per aligned word
// Notes: Byte address is four times the register index
package gpio_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int PA_W = 6;
    localparam int PB_W = 8;
    localparam int EVT_W = 7;
    // ----------------------------------------
    // Register indices
    // ----------------------------------------
    localparam logic [5:0] IDX_PA_DATA = 6'h00;
    localparam logic [5:0] IDX_PB_DATA = 6'h01;
    localparam logic [5:0] IDX_PA_DIR = 6'h04;
    localparam logic [5:0] IDX_PB_DIR = 6'h05;
    localparam logic [5:0] IDX_PA_PULL = 6'h0B;
    localparam logic [5:0] IDX_PB_PULL = 6'h0C;
    localparam logic [5:0] IDX_CONFIG = 6'h10;
    localparam logic [5:0] IDX_IRQ_STAT = 6'h11;
    localparam logic [5:0] IDX_IRQ_CLR = 6'h12;
    localparam logic [5:0] IDX_IRQ_EN = 6'h13;
    localparam logic [5:0] IDX_KEYPAD_EN = 6'h14;
    // ----------------------------------------
    // Field positions and masks
    // ----------------------------------------
    localparam int WAKE_BIT = 6;
    localparam int INPUT_ONLY_BIT = 2;
    localparam int OSC_SEL_BIT = 7;
    localparam int CFG_IRQ_BIT = 0;
    localparam int CFG_MODE_LSB = 1;
    localparam int IRQ_PIN_EVT_BIT = 6;
    localparam logic [7:0] PA_DIR_MASK = 8'h3B;
    localparam logic [7:0] PA_PULL_MASK = 8'hBF;
    localparam logic [7:0] CFG_MASK = 8'h07;
    localparam logic [7:0] KEYPAD_MASK = 8'h3F;
    localparam logic [7:0] EVT_MASK = 8'h7F;
    localparam logic [5:0] PA_OSC_MASK = 6'h10;
    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [7:0] DIR_RESET = 8'h00;
    localparam logic [7:0] PULL_RESET = 8'h00;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [5:0] PREV_RESET = 6'h3F;

    typedef enum logic [1:0] {
        OSC_INTERNAL = 2'b00,
        OSC_EXTERNAL = 2'b01,
        OSC_RC = 2'b10,
        OSC_XTAL = 2'b11
    } osc_mode_t;

    typedef enum logic {
        BUS_IDLE = 1'b0,
        BUS_ANSWER = 1'b1
    } bus_state_t;

    function automatic logic [DATA_W-1:0] zext8(input logic [7:0] v);
        return {24'h000000, v};
    endfunction
endpackage

//--- src/pin_if.sv
// Purpose: Carries one port's control and pin signals
// Assumes: Pins are synchronous to the core clock
// Notes: Driven by the top, consumed by the pin slice
`timescale 1ns/100ps
interface pin_if #(parameter int W = 8);
    logic [W-1:0] latch;
    logic [W-1:0] dir;
    logic [W-1:0] pull_en;
    logic [W-1:0] force_in;
    logic [W-1:0] alt_en;
    logic [W-1:0] alt_val;
    logic [W-1:0] pin;
    logic [W-1:0] rd;
    logic [W-1:0] out;
    logic [W-1:0] oe;
    logic [W-1:0] pull;
    modport slice (input latch, dir, pull_en, force_in, alt_en, alt_val,
        input pin, output rd, out, oe, pull);
    modport ctrl (output latch, dir, pull_en, force_in, alt_en, alt_val,
        output pin, input rd, out, oe, pull);
endinterface

//--- src/port_pin_slice.sv
// Purpose: Pin drive, pullup and readback for one port
// Assumes: Alternate function overrides data and direction
// Notes: Drive outputs are registered
`timescale 1ns/100ps
module port_pin_slice #(parameter int W = 8) (
    input wire logic clk_i,
    input wire logic nrst_i,
    pin_if.slice p
);
    logic [W-1:0] out_next;
    logic [W-1:0] oe_next;
    logic [W-1:0] pull_next;
    logic [W-1:0] out_reg;
    logic [W-1:0] oe_reg;
    logic [W-1:0] pull_reg;

    assign oe_next = p.alt_en | (p.dir & ~p.force_in);
    assign out_next = (p.alt_en & p.alt_val) | (~p.alt_en & p.latch & oe_next);
    assign pull_next = p.pull_en & ~p.dir & ~p.alt_en;
    assign p.rd = (p.dir & p.latch) | (~p.dir & p.pin);

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            out_reg <= '0;
            oe_reg <= '0;
            pull_reg <= '0;
        end else begin
            out_reg <= out_next;
            oe_reg <= oe_next;
            pull_reg <= pull_next;
        end
    end

    assign p.out = out_reg;
    assign p.oe = oe_reg;
    assign p.pull = pull_reg;

    pull_follow_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        ##1 ((p.pull & $past(p.dir)) == '0))
        else $error("pullup active on output pin");
endmodule

//--- src/event_status.sv
// Purpose: Sticky event bits, enables and one level interrupt
// Assumes: Clear strobe carries a write-one-to-clear mask
// Notes: A set in the clear cycle wins
`timescale 1ns/100ps
module event_status #(parameter int W = 7) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [W-1:0] set_i,
    input wire logic [W-1:0] clr_i,
    input wire logic clr_stb_i,
    input wire logic [W-1:0] en_i,
    output logic [W-1:0] status_o,
    output logic irq_o
);
    logic [W-1:0] status_reg;
    logic [W-1:0] status_next;
    logic irq_reg;

    assign status_next = set_i |
        (status_reg & ~(clr_stb_i ? clr_i : '0));

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            status_reg <= '0;
            irq_reg <= 1'b0;
        end else begin
            status_reg <= status_next;
            irq_reg <= |(status_next & en_i);
        end
    end

    assign status_o = status_reg;
    assign irq_o = irq_reg;

    set_wins_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (set_i != '0) |=> ((status_reg & $past(set_i)) == $past(set_i)))
        else $error("event lost against clear");
endmodule

//--- src/gpio_ports.sv
// Purpose: Two GPIO ports with direction, pullup and readback logic
// Assumes: Avalon-MM with waitrequest, byte lane 0 carries data
// Notes: Data latches are not reset
`timescale 1ns/100ps
module gpio_ports (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [gpio_pkg::ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [gpio_pkg::DATA_W-1:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [gpio_pkg::DATA_W-1:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic [gpio_pkg::PA_W-1:0] porta_pin_i,
    input wire logic [gpio_pkg::PB_W-1:0] portb_pin_i,
    input wire logic wakeup_request_i,
    input wire logic fast_osc_clock_i,
    output logic [gpio_pkg::PA_W-1:0] porta_out_o,
    output logic [gpio_pkg::PA_W-1:0] porta_oe_o,
    output logic [gpio_pkg::PA_W-1:0] porta_pull_o,
    output logic [gpio_pkg::PB_W-1:0] portb_out_o,
    output logic [gpio_pkg::PB_W-1:0] portb_oe_o,
    output logic [gpio_pkg::PB_W-1:0] portb_pull_o,
    output logic int_pin_level_o,
    output logic irq_o
);
    import gpio_pkg::*;

    // ----------------------------------------
    // State
    // ----------------------------------------
    bus_state_t bus_state_reg;
    bus_state_t bus_state_next;
    logic wait_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic [PA_W-1:0] pa_latch_reg;
    logic [PB_W-1:0] pb_latch_reg;
    logic [7:0] pa_dir_reg;
    logic [7:0] pb_dir_reg;
    logic [7:0] pa_pull_reg;
    logic [7:0] pb_pull_reg;
    logic [7:0] cfg_reg;
    logic [7:0] irq_en_reg;
    logic [7:0] keypad_reg;
    logic [PA_W-1:0] pa_prev_reg;
    logic int_level_reg;
    logic [EVT_W-1:0] evt_status;

    pin_if #(.W(PA_W)) pa_if();
    pin_if #(.W(PB_W)) pb_if();

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    wire [5:0] idx = avs_address_i[7:2];
    wire req = avs_read_i | avs_write_i;
    wire accept = req && (bus_state_reg == BUS_ANSWER);
    wire wr_en = avs_write_i && accept && avs_byteenable_i[0];
    wire [7:0] wd = avs_writedata_i[7:0];
    wire sel_pa_data = wr_en && (idx == IDX_PA_DATA);
    wire sel_pb_data = wr_en && (idx == IDX_PB_DATA);
    wire sel_pa_dir = wr_en && (idx == IDX_PA_DIR);
    wire sel_pb_dir = wr_en && (idx == IDX_PB_DIR);
    wire sel_pa_pull = wr_en && (idx == IDX_PA_PULL);
    wire sel_pb_pull = wr_en && (idx == IDX_PB_PULL);
    wire sel_cfg = wr_en && (idx == IDX_CONFIG);
    wire sel_clr = wr_en && (idx == IDX_IRQ_CLR);
    wire sel_irq_en = wr_en && (idx == IDX_IRQ_EN);
    wire sel_keypad = wr_en && (idx == IDX_KEYPAD_EN);

    // ----------------------------------------
    // Mode decode
    // ----------------------------------------
    wire irq_fn = cfg_reg[CFG_IRQ_BIT];
    wire [1:0] mode_bits = cfg_reg[CFG_MODE_LSB +: 2];
    wire osc_mode_ok = (mode_bits == OSC_INTERNAL) || (mode_bits == OSC_RC);
    wire osc_route = pa_pull_reg[OSC_SEL_BIT] && osc_mode_ok;

    wire [PA_W-1:0] pa_rd_mask = irq_fn ?
        ~PA_W'(1 << INPUT_ONLY_BIT) : '1;
    wire [7:0] pa_read = {1'b0, wakeup_request_i, pa_if.rd & pa_rd_mask};

    wire [7:0] read_byte =
        (idx == IDX_PA_DATA) ? pa_read :
        (idx == IDX_PB_DATA) ? pb_if.rd :
        (idx == IDX_PA_DIR) ? pa_dir_reg :
        (idx == IDX_PB_DIR) ? pb_dir_reg :
        (idx == IDX_PA_PULL) ? pa_pull_reg :
        (idx == IDX_PB_PULL) ? pb_pull_reg :
        (idx == IDX_CONFIG) ? cfg_reg :
        (idx == IDX_IRQ_STAT) ? {1'b0, evt_status} :
        (idx == IDX_IRQ_EN) ? irq_en_reg :
        (idx == IDX_KEYPAD_EN) ? keypad_reg : 8'h00;

    // ----------------------------------------
    // Events
    // ----------------------------------------
    // Keypad falling edges
    wire [PA_W-1:0] key_fall = keypad_reg[PA_W-1:0] & pa_prev_reg &
        ~porta_pin_i & ~(osc_route ? PA_OSC_MASK : '0);
    wire irq_fall = irq_fn && pa_prev_reg[INPUT_ONLY_BIT] &&
        !porta_pin_i[INPUT_ONLY_BIT];
    wire [EVT_W-1:0] evt_set = {irq_fall, key_fall};

    // ----------------------------------------
    // Bus state machine
    // ----------------------------------------
    always_comb begin
        bus_state_next = bus_state_reg;
        case (bus_state_reg)
            BUS_IDLE: begin
                if (req) begin
                    bus_state_next = BUS_ANSWER;
                end
            end
            BUS_ANSWER: bus_state_next = BUS_IDLE;
            default: bus_state_next = BUS_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            bus_state_reg <= BUS_IDLE;
            wait_reg <= 1'b1;
            rdata_reg <= '0;
        end else begin
            bus_state_reg <= bus_state_next;
            wait_reg <= !(req && (bus_state_reg == BUS_IDLE));
            if (avs_read_i && (bus_state_reg == BUS_IDLE)) begin
                rdata_reg <= zext8(read_byte);
            end
        end
    end

    // ----------------------------------------
    // Data latches
    // ----------------------------------------
    // Latches without reset
    always_ff @(posedge clk_i) begin
        if (sel_pa_data) begin
            pa_latch_reg <= wd[PA_W-1:0];
        end
        if (sel_pb_data) begin
            pb_latch_reg <= wd;
        end
    end

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            pa_dir_reg <= DIR_RESET;
            pb_dir_reg <= DIR_RESET;
            pa_pull_reg <= PULL_RESET;
            pb_pull_reg <= PULL_RESET;
            cfg_reg <= CFG_RESET;
            irq_en_reg <= CFG_RESET;
            keypad_reg <= CFG_RESET;
        end else begin
            if (sel_pa_dir) begin
                pa_dir_reg <= wd & PA_DIR_MASK;
            end
            if (sel_pb_dir) begin
                pb_dir_reg <= wd;
            end
            if (sel_pa_pull) begin
                pa_pull_reg <= wd & PA_PULL_MASK;
            end
            if (sel_pb_pull) begin
                pb_pull_reg <= wd;
            end
            if (sel_cfg) begin
                cfg_reg <= wd & CFG_MASK;
            end
            if (sel_irq_en) begin
                irq_en_reg <= wd & EVT_MASK;
            end
            if (sel_keypad) begin
                keypad_reg <= wd & KEYPAD_MASK;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            pa_prev_reg <= PREV_RESET;
            int_level_reg <= 1'b1;
        end else begin
            pa_prev_reg <= porta_pin_i;
            int_level_reg <= irq_fn ? porta_pin_i[INPUT_ONLY_BIT] : 1'b1;
        end
    end

    // ----------------------------------------
    // Pin slices
    // ----------------------------------------
    assign pa_if.latch = pa_latch_reg;
    assign pa_if.dir = pa_dir_reg[PA_W-1:0];
    assign pa_if.pull_en = pa_pull_reg[PA_W-1:0];
    assign pa_if.force_in = keypad_reg[PA_W-1:0];
    assign pa_if.alt_en = osc_route ? PA_OSC_MASK : '0;
    assign pa_if.alt_val = {PA_W{fast_osc_clock_i}};
    assign pa_if.pin = porta_pin_i;
    assign pb_if.latch = pb_latch_reg;
    assign pb_if.dir = pb_dir_reg;
    assign pb_if.pull_en = pb_pull_reg;
    assign pb_if.force_in = '0;
    assign pb_if.alt_en = '0;
    assign pb_if.alt_val = '0;
    assign pb_if.pin = portb_pin_i;

    port_pin_slice #(.W(PA_W)) u_pa (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .p(pa_if)
    );

    port_pin_slice #(.W(PB_W)) u_pb (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .p(pb_if)
    );

    event_status #(.W(EVT_W)) u_evt (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .set_i(evt_set),
        .clr_i(wd[EVT_W-1:0]),
        .clr_stb_i(sel_clr),
        .en_i(irq_en_reg[EVT_W-1:0]),
        .status_o(evt_status),
        .irq_o(irq_o)
    );

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign avs_readdata_o = rdata_reg;
    assign avs_waitrequest_o = wait_reg;
    assign porta_out_o = pa_if.out;
    assign porta_oe_o = pa_if.oe;
    assign porta_pull_o = pa_if.pull;
    assign portb_out_o = pb_if.out;
    assign portb_oe_o = pb_if.oe;
    assign portb_pull_o = pb_if.pull;
    assign int_pin_level_o = int_level_reg;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    wait_answer_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (req && bus_state_reg == BUS_IDLE) |=> !avs_waitrequest_o ##1
        avs_waitrequest_o)
        else $error("waitrequest answer timing wrong");
    dir_reset_a: assert property (@(posedge clk_i)
        !nrst_i |=> (pa_dir_reg == 8'h00 && pb_dir_reg == 8'h00 &&
        pb_pull_reg == 8'h00))
        else $error("direction not cleared by reset");
    input_only_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !porta_oe_o[INPUT_ONLY_BIT] && !pa_dir_reg[INPUT_ONLY_BIT])
        else $error("input only pin driven");
    latch_write_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        sel_pa_data |=> pa_latch_reg == $past(wd[PA_W-1:0]))
        else $error("latch write lost");
    dir_drive_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (sel_pa_dir && wd[0] && !keypad_reg[0]) |=> ##1 porta_oe_o[0])
        else $error("direction write did not enable driver");
    irq_mask_read_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (avs_read_i && bus_state_reg == BUS_IDLE && idx == IDX_PA_DATA &&
        irq_fn) |=> !avs_readdata_o[INPUT_ONLY_BIT])
        else $error("bit 2 not masked");
    wake_read_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (avs_read_i && bus_state_reg == BUS_IDLE && idx == IDX_PA_DATA)
        |=> avs_readdata_o[WAKE_BIT] == $past(wakeup_request_i))
        else $error("wakeup readback wrong");
    latch_read_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (avs_read_i && bus_state_reg == BUS_IDLE && idx == IDX_PB_DATA &&
        pb_dir_reg[0]) |=> avs_readdata_o[0] == $past(pb_latch_reg[0]))
        else $error("output pin readback not latch");
    branch_level_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !irq_fn |=> int_pin_level_o)
        else $error("branch level not high");
    osc_route_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        osc_route |=> porta_oe_o[4] &&
        porta_out_o[4] == $past(fast_osc_clock_i))
        else $error("osc clock not on pin 4");
    reserved_bit_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        sel_pa_pull |=> !pa_pull_reg[6] && !pa_dir_reg[7])
        else $error("reserved bit stored");
    keypad_input_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        keypad_reg[0] |=> !porta_oe_o[0])
        else $error("keypad pin driven");
    pa_pull_off_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (pa_dir_reg != 8'h00) |=> ((porta_pull_o &
        $past(pa_dir_reg[PA_W-1:0])) == '0))
        else $error("port a pullup on output pin");
    pb_pull_off_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (pb_dir_reg != 8'h00) |=> ((portb_pull_o & $past(pb_dir_reg)) ==
        '0))
        else $error("port b pullup on output pin");
    irq_level_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        1'b1 |=> irq_o == |(evt_status &
        $past(irq_en_reg[EVT_W-1:0])))
        else $error("interrupt level wrong");
    pull_reset_a: assert property (@(posedge clk_i)
        !nrst_i |=> (pa_pull_reg == 8'h00 && cfg_reg == 8'h00 &&
        keypad_reg == 8'h00))
        else $error("pullup or config not cleared");
    pb_oe_follow_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        1'b1 |=> portb_oe_o == $past(pb_dir_reg))
        else $error("port b driver not following direction");
    int_level_pin_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        irq_fn |=> int_pin_level_o == $past(porta_pin_i[INPUT_ONLY_BIT]))
        else $error("branch level not pin level");
    key_event_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (keypad_reg[0] && pa_prev_reg[0] && !porta_pin_i[0]) |=>
        evt_status[0])
        else $error("keypad edge not flagged");
    osc_off_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (!osc_route && !pa_dir_reg[4]) |=> !porta_oe_o[4])
        else $error("pin 4 driven without route");
endmodule

//--- tb/pin_board.sv
// Purpose: Board model of the port pins
// Assumes: A driven pin wins, then its pullup, then the board level
// Notes: Levels settle combinationally
`timescale 1ns/100ps
module pin_board #(parameter int W = 6) (
    input wire logic [W-1:0] out_i,
    input wire logic [W-1:0] oe_i,
    input wire logic [W-1:0] pull_i,
    input wire logic [W-1:0] ext_i,
    output logic [W-1:0] pin_o
);
    assign pin_o = (oe_i & out_i) | (~oe_i & (pull_i | ext_i));
endmodule

//--- tb/tb.sv
// Purpose: Self-checking bench for the dual GPIO ports
// Assumes: Avalon-MM master, one register per word
// Notes: Expected values are worked out by hand per scenario
`timescale 1ns/100ps
module tb;
    import gpio_pkg::*;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [ADDR_W-1:0] adr = '0;
    logic rd_req = 1'b0;
    logic wr_req = 1'b0;
    logic [DATA_W-1:0] wdat = '0;
    logic [3:0] be = 4'hF;
    logic [DATA_W-1:0] rdat;
    logic wait_o;
    logic wake = 1'b0;
    logic osc = 1'b0;
    logic [PA_W-1:0] pa_pin, pa_out, pa_oe, pa_pull;
    logic [PA_W-1:0] pa_ext = 6'h04;
    logic [PB_W-1:0] pb_pin, pb_out, pb_oe, pb_pull;
    logic [PB_W-1:0] pb_ext = 8'h00;
    logic int_lvl, irq;
    int err_count = 0;
    int samples_checked = 0;

    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) osc <= ~osc;

    gpio_ports i_dut (.clk_i(clk_i), .nrst_i(nrst_i), .avs_address_i(adr),
        .avs_read_i(rd_req), .avs_write_i(wr_req), .avs_writedata_i(wdat),
        .avs_byteenable_i(be), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wait_o), .porta_pin_i(pa_pin),
        .portb_pin_i(pb_pin), .wakeup_request_i(wake),
        .fast_osc_clock_i(osc), .porta_out_o(pa_out), .porta_oe_o(pa_oe),
        .porta_pull_o(pa_pull), .portb_out_o(pb_out), .portb_oe_o(pb_oe),
        .portb_pull_o(pb_pull), .int_pin_level_o(int_lvl), .irq_o(irq));
    pin_board #(.W(PA_W)) i_pa (.out_i(pa_out), .oe_i(pa_oe),
        .pull_i(pa_pull), .ext_i(pa_ext), .pin_o(pa_pin));
    pin_board #(.W(PB_W)) i_pb (.out_i(pb_out), .oe_i(pb_oe),
        .pull_i(pb_pull), .ext_i(pb_ext), .pin_o(pb_pin));

    // ----------------------------------------
    // Bus and check helpers
    // ----------------------------------------
    task automatic bus(input logic wr, input logic [5:0] idx,
        input logic [7:0] wd, output logic [7:0] rv);
        @(posedge clk_i);
        adr <= {idx, 2'b00};
        wr_req <= wr;
        rd_req <= ~wr;
        wdat <= {24'h000000, wd};
        do begin
            @(posedge clk_i);
        end while (wait_o !== 1'b0);
        rv = rdat[7:0];
        wr_req <= 1'b0;
        rd_req <= 1'b0;
        be <= 4'hF;
    endtask
    task automatic chk(input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        logic [7:0] v;
        bus(1'b1, idx, d, v);
    endtask
    task automatic rdchk(input logic [5:0] idx, input logic [7:0] exp);
        logic [7:0] v;
        bus(1'b0, idx, 8'h00, v);
        chk(exp, v);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic stop_test();
        $display("errors %0d checks %0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        chk(8'h00, {2'b00, pa_oe});
        rdchk(IDX_PA_DIR, 8'h00);
        rdchk(IDX_PA_PULL, 8'h00);
        rdchk(IDX_PB_DIR, 8'h00);
        rdchk(IDX_PB_PULL, 8'h00);
        wr(6'h20, 8'hFF);
        rdchk(6'h20, 8'h00);
        idle(1);
        be <= 4'h0;
        wr(IDX_PB_DIR, 8'hFF);
        rdchk(IDX_PB_DIR, 8'h00);
    endtask
    task automatic t_dir_a();
        wake <= 1'b1;
        wr(IDX_PA_DATA, 8'h2A);
        rdchk(IDX_PA_DATA, 8'h44);
        wr(IDX_PA_DIR, 8'hFF);
        rdchk(IDX_PA_DIR, 8'h3B);
        rdchk(IDX_PA_DATA, 8'h6E);
        chk(8'h3B, {2'b00, pa_oe});
        chk(8'h2A, {2'b00, pa_out & pa_oe});
        wr(IDX_PA_DATA, 8'h51);
        wake <= 1'b0;
        idle(3);
        rdchk(IDX_PA_DATA, 8'h15);
    endtask
    task automatic t_pull();
        wr(IDX_PA_DIR, 8'h03);
        wr(IDX_PA_PULL, 8'hFF);
        rdchk(IDX_PA_PULL, 8'hBF);
        chk(8'h2C, {2'b00, pa_pull});
        chk(8'h13, {2'b00, pa_oe});
        wr(IDX_CONFIG, 8'h02);
        idle(2);
        chk(8'h03, {2'b00, pa_oe});
        wr(IDX_CONFIG, 8'h06);
        idle(2);
        chk(8'h03, {2'b00, pa_oe});
        wr(IDX_CONFIG, 8'h04);
        idle(2);
        chk(8'h13, {2'b00, pa_oe});
        wr(IDX_PA_PULL, 8'h3F);
        idle(2);
        chk(8'h3C, {2'b00, pa_pull});
        wr(IDX_PB_DIR, 8'hF0);
        wr(IDX_PB_PULL, 8'hFF);
        wr(IDX_PB_DATA, 8'hA5);
        chk(8'h0F, pb_pull);
        chk(8'hF0, pb_oe);
        rdchk(IDX_PB_DATA, 8'hAF);
        chk(8'hA0, pb_out & pb_oe);
    endtask
    task automatic t_irq();
        wr(IDX_PA_PULL, 8'h00);
        wr(IDX_PA_DIR, 8'h00);
        pa_ext <= 6'h3F;
        wr(IDX_KEYPAD_EN, 8'h01);
        wr(IDX_CONFIG, 8'h01);
        wr(IDX_IRQ_CLR, 8'h7F);
        wr(IDX_IRQ_EN, 8'h41);
        rdchk(IDX_PA_DATA, 8'h3B);
        chk(8'h01, {7'h00, int_lvl});
        chk(8'h00, {7'h00, irq});
        pa_ext <= 6'h3A;
        idle(4);
        chk(8'h00, {7'h00, int_lvl});
        chk(8'h01, {7'h00, irq});
        rdchk(IDX_IRQ_STAT, 8'h41);
        wr(IDX_IRQ_EN, 8'h00);
        idle(2);
        chk(8'h00, {7'h00, irq});
        wr(IDX_IRQ_CLR, 8'h41);
        rdchk(IDX_IRQ_STAT, 8'h00);
        wr(IDX_CONFIG, 8'h00);
        rdchk(IDX_PA_DATA, 8'h3A);
        chk(8'h01, {7'h00, int_lvl});
        wr(IDX_PA_DIR, 8'h03);
        idle(2);
        chk(8'h02, {2'b00, pa_oe});
    endtask
    task automatic t_keep();
        wr(IDX_PA_DATA, 8'h21);
        wr(IDX_PB_DATA, 8'h5A);
        nrst_i <= 1'b0;
        idle(2);
        nrst_i <= 1'b1;
        rdchk(IDX_PA_DIR, 8'h00);
        wr(IDX_PA_DIR, 8'hFF);
        wr(IDX_PB_DIR, 8'hFF);
        rdchk(IDX_PA_DATA, 8'h21);
        rdchk(IDX_PB_DATA, 8'h5A);
    endtask

    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        idle(12);
        nrst_i <= 1'b1;
        t_reset();
        t_dir_a();
        t_pull();
        t_irq();
        t_keep();
        stop_test();
    end
    initial begin
        idle(3000);
        err_count++;
        stop_test();
    end
endmodule
